// ### frmc_pkg.sv
package frmc_pkg;
  localparam int unsigned addr_w = 8;
  localparam int unsigned data_w = 32;
  // register offsets
  localparam logic [7:0] off_mode = 8'h00;
  localparam logic [7:0] off_wprot = 8'h04;
  localparam logic [7:0] off_status = 8'h08;
  // mode and write protect register fields
  localparam int unsigned bit_loop = 26;
  localparam int unsigned bit_seq = 16;
  localparam int unsigned fws_lo = 8;
  localparam int unsigned fws_w = 4;
  localparam int unsigned bit_rdy_ie = 0;
  localparam int unsigned bit_write_protect_enable = 0;
  localparam logic [3:0] fws_reset = 4'h0;
  localparam logic [31:0] mode_mask = 32'h0401_0f01;
  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } frmc_req_t;
  // flash access request from fetch path
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } frmc_acc_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait = 2'b01,
    st_done = 2'b10
  } frmc_state_t;
endpackage : frmc_pkg

// ### frmc_waitgen.sv
`timescale 1ns/1ps
`default_nettype none
// stretches one flash access to wait states plus one cycles
module frmc_waitgen #(
  parameter int unsigned FWS_W = 4
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic [FWS_W-1:0] fws_i,
  output logic busy_o,
  output logic done_o
);
  import frmc_pkg::*;
  frmc_state_t state_q, state_d;
  logic [FWS_W-1:0] cnt_q, cnt_d;
  // count value seen in the closing cycle of a stretched access
  localparam logic [FWS_W-1:0] cnt_last = {{(FWS_W-1){1'b0}}, 1'b1};
  wire last_wait = (state_q == st_wait) && (cnt_q == cnt_last);
  // count down the wait states latched at start; a zero count never
  // leaves idle, its single cycle closes combinationally
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      st_idle: begin
        if (start_i && fws_i != '0) begin
          cnt_d = fws_i;
          state_d = st_wait;
        end
      end
      st_wait: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == cnt_last) begin
          state_d = st_idle;
        end
      end
      default: state_d = st_idle;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_q <= st_idle;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end
  // busy comes from flops only, so ready never loops back through start
  assign busy_o = (state_q == st_wait);
  // done marks cycle start + fws, the last of fws + 1 cycles
  assign done_o = last_wait ||
    (state_q == st_idle && start_i && fws_i == '0);
endmodule : frmc_waitgen
`default_nettype wire

// ### frmc_top.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1 writes to the mode register are ignored while write protect is set
// RULE2 bit 26 set enables opcode loop optimization of fetches
// RULE3 bit 16 clear enables sequential code optimization, set turns it off
// RULE4 bits 11:8 give wait states; each access takes value plus one cycles
// RULE5 bit 0 enables the interrupt when the flash becomes ready
// RULE6 software must not read flash while changing either optimization bit
// RULE7 interrupt is high only while ready and its enable are both true
module frmc_top #(
  parameter int unsigned FWS_W = frmc_pkg::fws_w
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire frmc_pkg::frmc_req_t reg_req_i,
  output logic [31:0] reg_rdata_o,
  input wire frmc_pkg::frmc_acc_t acc_i,
  output logic acc_ready_o,
  output logic acc_done_o,
  input wire logic flash_ready_i,
  output logic loop_opt_en_o,
  output logic seq_opt_en_o,
  output logic [FWS_W-1:0] wait_states_o,
  output logic irq_o
);
  import frmc_pkg::*;
  logic write_protect_enable_q;
  logic loop_optimization_enable_q;
  logic sequential_optim_disable_q;
  logic [FWS_W-1:0] flash_wait_states_q;
  logic ready_interrupt_enable_q;
  logic [31:0] rdata_q;
  logic busy;
  logic done;

  // address decode
  wire sel_mode = (reg_req_i.addr == off_mode);
  wire sel_wprot = (reg_req_i.addr == off_wprot);
  wire sel_status = (reg_req_i.addr == off_status);
  wire wr_mode = reg_req_i.wr && sel_mode && !write_protect_enable_q; // RULE1
  wire wr_wprot = reg_req_i.wr && sel_wprot;

  // places each setting at its own field position; reserved bits read zero
  function automatic logic [data_w-1:0] mode_pack(input logic loop_en,
      input logic seq_dis, input logic [FWS_W-1:0] flash_wait_states,
      input logic rdy_ie);
    logic [data_w-1:0] img;
    img = '0;
    img[bit_loop] = loop_en; // RULE2
    img[bit_seq] = seq_dis; // RULE3
    img[fws_lo +: FWS_W] = flash_wait_states; // RULE4
    img[bit_rdy_ie] = rdy_ie; // RULE5
    return img;
  endfunction : mode_pack

  // read image of the mode register
  wire [31:0] mode_img = mode_pack(loop_optimization_enable_q,
    sequential_optim_disable_q, flash_wait_states_q,
    ready_interrupt_enable_q);
  wire [31:0] status_img = {29'h0, busy, flash_ready_i, irq_o};
  wire [31:0] rd_mux = sel_mode ? mode_img :
    sel_wprot ? {31'h0, write_protect_enable_q} :
    sel_status ? status_img : 32'h0;

  // register writes; protect register itself stays writable
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      write_protect_enable_q <= 1'b0;
      loop_optimization_enable_q <= 1'b0;
      sequential_optim_disable_q <= 1'b0;
      flash_wait_states_q <= fws_reset;
      ready_interrupt_enable_q <= 1'b0;
    end else begin
      if (wr_wprot) begin
        write_protect_enable_q <= reg_req_i.wdata[bit_write_protect_enable];
      end
      if (wr_mode) begin
        loop_optimization_enable_q <= reg_req_i.wdata[bit_loop]; // RULE2
        sequential_optim_disable_q <= reg_req_i.wdata[bit_seq]; // RULE3
        flash_wait_states_q <= reg_req_i.wdata[fws_lo +: FWS_W]; // RULE4
        ready_interrupt_enable_q <= reg_req_i.wdata[bit_rdy_ie]; // RULE5
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_req_i.rd ? rd_mux : 32'h0;
    end
  end
  assign reg_rdata_o = rdata_q;

  // settings steering the fetch path; relies on quiet fetches while changed
  assign loop_opt_en_o = loop_optimization_enable_q; // RULE2 RULE6
  assign seq_opt_en_o = !sequential_optim_disable_q; // RULE3 RULE6
  assign wait_states_o = flash_wait_states_q;

  // access timing; a request is taken only while no access is in flight,
  // so a request held through its done cycle is never taken twice
  wire acc_start = acc_i.valid && acc_ready_o;
  frmc_waitgen #(
    .FWS_W(FWS_W)
  ) u_wait (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .start_i(acc_start),
    .fws_i(flash_wait_states_q), // RULE4
    .busy_o(busy),
    .done_o(done)
  );
  assign acc_ready_o = !busy; // RULE4
  assign acc_done_o = done;

  // cycles an access has run, for the timing checks below; the wait count
  // is latched at start because software may retune it between reads
  logic [FWS_W-1:0] acc_age_q;
  logic [FWS_W-1:0] acc_fws_q;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || done) begin
      acc_age_q <= '0;
    end else if (acc_start || busy) begin
      acc_age_q <= acc_age_q + 1'b1;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      acc_fws_q <= '0;
    end else if (acc_start) begin
      acc_fws_q <= flash_wait_states_q;
    end
  end

  // interrupt is a plain level, no sticky state
  assign irq_o = flash_ready_i && ready_interrupt_enable_q; // RULE5 RULE7

  a_mode_protect: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    reg_req_i.wr && sel_mode && write_protect_enable_q |=>
    $stable(mode_img)) // RULE1
    else $error("mode register changed while protected");
  a_loop_bit: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    wr_mode |=> loop_opt_en_o == $past(reg_req_i.wdata[bit_loop])) // RULE2
    else $error("loop enable not taken from bit 26");
  a_seq_bit: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    wr_mode |=> seq_opt_en_o != $past(reg_req_i.wdata[bit_seq])) // RULE3
    else $error("sequential optimization polarity wrong");
  a_wait_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    acc_i.valid && !busy && flash_wait_states_q == 4'h0 |-> done) // RULE4
    else $error("zero wait access not single cycle");
  // one wait state: a quiet start cycle, then the closing cycle
  sequence s_one_wait;
    !done ##1 done;
  endsequence
  a_wait_one: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    acc_i.valid && !busy && flash_wait_states_q == 4'h1 |->
    s_one_wait) // RULE4
    else $error("one wait access not two cycles");
  a_irq_gate: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    irq_o |-> ready_interrupt_enable_q) // RULE5
    else $error("interrupt without enable");
  a_irq_level: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    flash_ready_i && ready_interrupt_enable_q |-> irq_o) // RULE7
    else $error("interrupt missing while ready and enabled");
  a_irq_drop: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $fell(flash_ready_i) |-> !irq_o) // RULE7
    else $error("interrupt held after ready fell");

  // register side: what an accepted write leaves behind, and read data between reads
  // protect bit follows every write to its own register
  a_wprot_take: assert property ( // RULE1
    @(posedge clk_sys_i) disable iff (srst_i)
    wr_wprot |=> write_protect_enable_q == $past(reg_req_i.wdata[bit_write_protect_enable]))
    else $error("protect bit not taken from write data");
  // an open write lands every field and nothing else
  a_mode_open: assert property ( // RULE1
    @(posedge clk_sys_i) disable iff (srst_i)
    wr_mode |=> mode_img == ($past(reg_req_i.wdata) & mode_mask))
    else $error("open mode write not stored");
  // wait state field reaches the fetch path unchanged
  a_fws_take: assert property ( // RULE4
    @(posedge clk_sys_i) disable iff (srst_i)
    wr_mode |=> wait_states_o == $past(reg_req_i.wdata[fws_lo +: FWS_W]))
    else $error("wait states not taken from bits 11 to 8");
  // ready enable taken from bit 0
  a_ie_take: assert property ( // RULE5
    @(posedge clk_sys_i) disable iff (srst_i)
    wr_mode |=> ready_interrupt_enable_q == $past(reg_req_i.wdata[bit_rdy_ie]))
    else $error("ready enable not taken from bit 0");
  // read data is zero outside the cycle after a read strobe
  a_rdata_idle: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    !reg_req_i.rd |=> reg_rdata_o == '0)
    else $error("read data shown without a read");

  // fetch side: no new access while one is stretched
  a_ready_busy: assert property ( // RULE4
    @(posedge clk_sys_i) disable iff (srst_i)
    busy |-> !acc_ready_o)
    else $error("new access offered while busy");
  // a stretched access closes exactly at its latched count
  a_wait_count: assert property ( // RULE4
    @(posedge clk_sys_i) disable iff (srst_i)
    busy && done |-> acc_age_q == acc_fws_q)
    else $error("access closed at the wrong cycle");
  // and never before it
  a_wait_early: assert property ( // RULE4
    @(posedge clk_sys_i) disable iff (srst_i)
    busy && acc_age_q != acc_fws_q |-> !done)
    else $error("access closed early");
endmodule : frmc_top
`default_nettype wire

// ### frmc_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
// fetch side: holds a request until done and counts its cycles
module frmc_fetch_model
  import frmc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic go_i,
  input wire logic done_i,
  output var frmc_pkg::frmc_acc_t acc_o,
  output var int len_o
);
  initial acc_o = '0;
  initial len_o = 0;
  // idle address wanders so a stale value is never trusted
  always @(posedge clk_sys_i) begin
    if (!acc_o.valid) begin
      acc_o.addr <= ~acc_o.addr;
      if (go_i) begin
        acc_o.valid <= 1'b1;
        acc_o.write <= ~acc_o.write;
        len_o <= 1;
      end
    end else if (done_i) begin
      acc_o.valid <= 1'b0;
    end else begin
      len_o <= len_o + 1;
    end
  end
endmodule : frmc_fetch_model
`default_nettype wire

// ### frmc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); n_mismatch++; end end
module frmc_top_tb;
  import frmc_pkg::*;
  logic clk_sys_i = 0, srst_i = 1, fr = 0, go = 0;
  frmc_req_t req = '0;
  frmc_acc_t acc;
  logic [31:0] rd;
  logic rdy, done, loop, seq, irq;
  logic [3:0] ws;
  int len, n_mismatch = 0, check_count = 0, cyc = 0;
  frmc_top frmc_top_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .reg_req_i(req), .reg_rdata_o(rd), .acc_i(acc), .acc_ready_o(rdy),
    .acc_done_o(done), .flash_ready_i(fr), .loop_opt_en_o(loop),
    .seq_opt_en_o(seq), .wait_states_o(ws), .irq_o(irq));
  frmc_fetch_model frmc_fetch_model_inst (.clk_sys_i(clk_sys_i),
    .go_i(go), .done_i(done), .acc_o(acc), .len_o(len));
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  // one strobe cycle; read data is looked at in the cycle after
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys_i);
    req <= {a, d, w, ~w};
    @(posedge clk_sys_i);
    req <= '0;
    #1;
  endtask : bus
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    `CHK("rdata", e, rd)
  endtask : chk_rd
  task automatic t_reset();
    #1;
    `CHK("loop", 1'b0, loop)
    `CHK("seq", 1'b1, seq)
    `CHK("ws", 4'h0, ws)
    chk_rd(off_mode, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_fields();
    bus(1'b1, off_mode, 32'hffff_ffff);
    `CHK("loop", 1'b1, loop)
    `CHK("seq", 1'b0, seq)
    `CHK("ws", 4'hf, ws)
    chk_rd(off_mode, mode_mask);
    $display("t_fields done");
  endtask : t_fields
  task automatic t_protect();
    bus(1'b1, off_wprot, 32'h1);
    chk_rd(off_wprot, 32'h1);
    bus(1'b1, off_mode, 32'h0);
    chk_rd(off_mode, mode_mask);
    bus(1'b1, off_wprot, 32'h0);
    bus(1'b1, off_mode, 32'h0);
    `CHK("loop", 1'b0, loop)
    chk_rd(8'h40, 32'h0);
    $display("t_protect done");
  endtask : t_protect
  task automatic t_waits();
    logic [3:0] f [4] = '{4'h0, 4'h1, 4'h5, 4'hf};
    foreach (f[i]) begin
      // mode is only changed while no fetch is in flight
      bus(1'b1, off_mode, {20'h0, f[i], 8'h0});
      `CHK("ready", 1'b1, rdy)
      @(posedge clk_sys_i);
      go <= 1'b1;
      @(posedge clk_sys_i);
      go <= 1'b0;
      #1;
      // start cycle: only a zero count closes at once
      `CHK("first done", f[i] == 4'h0, done)
      @(posedge clk_sys_i);
      #1;
      `CHK("ready", f[i] == 4'h0, rdy)
      for (int k = 0; k < 20 && acc.valid; k++) @(posedge clk_sys_i);
      #1;
      `CHK("len", int'(f[i]) + 1, len)
    end
    $display("t_waits done");
  endtask : t_waits
  task automatic t_irq();
    @(posedge clk_sys_i);
    fr <= 1'b1;
    #1;
    `CHK("irq", 1'b0, irq)
    bus(1'b1, off_mode, 32'h1);
    `CHK("irq", 1'b1, irq)
    chk_rd(off_status, 32'h3);
    @(posedge clk_sys_i);
    fr <= 1'b0;
    #1;
    `CHK("irq", 1'b0, irq)
    $display("t_irq done");
  endtask : t_irq
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // hang guard: the tests need under a hundred cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    t_reset();
    t_fields();
    t_protect();
    t_waits();
    t_irq();
    print_verdict();
  end
endmodule : frmc_top_tb
`default_nettype wire
